/* File: bench/test_timer_pwm_unit.sv */
// Self-checking bench for the timer/PWM unit: overflow, compare and
// capture flags, flag clearing, counter clear and halted reads.
// Assumes the unit alone on one clock; strobes driven at falling edges.
`timescale 1ns/100ps
module test_timer_pwm_unit;
  import timer_pwm_pkg::*;
  localparam int TSC = 0, CNTW = 1, CNTR = 2, MODW = 4, OVF = 6;
  localparam int CHSC = 8, CVW = 9, CVR = 11, CHF = 13;
  logic                core_clk_i        = 1'b0;
  logic                rst_b_i           = 1'b0;
  logic                debug_halt_mode_i = 1'b0;
  logic [7:0]          wdata_i           = 8'h00;
  logic [14:0]         stb               = 15'h0000;
  tsc_cfg_t            tsc_cfg_i         = TSC_RST;
  ch_cfg_t             ch_cfg_i          = CH_CFG_RST;
  logic [NUM_CH-1:0]   ch_pin_i          = 2'h0;
  logic [7:0]          rdata_o;
  logic                overflow_flag_o;
  logic [NUM_CH-1:0]   channel_event_flag_o;
  logic [NUM_CH-1:0]   channel_out_o;
  logic [15:0]         counter_value_o;
  logic [15:0]         mod, cv, v;
  int                  mismatches = 0, n_compared = 0, e;

  always #2.5 core_clk_i = ~core_clk_i;

  timer_pwm_unit dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
    .debug_halt_mode_i(debug_halt_mode_i), .wdata_i(wdata_i),
    .tsc_wr_i(stb[0]), .tsc_cfg_i(tsc_cfg_i), .cnt_wr_i(stb[1]),
    .cnt_rd_hi_i(stb[2]), .cnt_rd_lo_i(stb[3]), .mod_wr_hi_i(stb[4]),
    .mod_wr_lo_i(stb[5]), .ovf_rd_i(stb[6]), .ovf_clr_i(stb[7]),
    .ch_sel_i(1'b0), .chsc_wr_i(stb[8]), .ch_cfg_i(ch_cfg_i),
    .cv_wr_hi_i(stb[9]), .cv_wr_lo_i(stb[10]), .cv_rd_hi_i(stb[11]),
    .cv_rd_lo_i(stb[12]), .ch_flag_rd_i(stb[13]),
    .ch_flag_clr_i(stb[14]), .ch_pin_i(ch_pin_i), .rdata_o(rdata_o),
    .overflow_flag_o(overflow_flag_o),
    .channel_event_flag_o(channel_event_flag_o),
    .channel_out_o(channel_out_o), .counter_value_o(counter_value_o));

  task test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Capture flag expected after one pin edge under an edge select code
  function automatic logic [15:0] cap_exp(input int els, input int rising);
    logic [1:0] want;
    want = (rising != 0) ? ELS_RISE : ELS_FALL;
    return 16'((2'(els) & want) != 2'h0);
  endfunction

  // One-cycle pulse seen by exactly one rising edge
  task strobe(input int i);
    @(negedge core_clk_i);
    stb[i] = 1'b1;
    @(negedge core_clk_i);
    stb[i] = 1'b0;
  endtask

  task wr16(input int i, input logic [15:0] d);
    wdata_i = d[15:8];
    strobe(i);
    wdata_i = d[7:0];
    strobe(i + 1);
  endtask

  task rd16(input int i, output logic [15:0] d);
    strobe(i);
    d[15:8] = rdata_o;
    strobe(i + 1);
    d[7:0] = rdata_o;
  endtask

  // Bounded wait: overflow flag (w=0) or channel 0 flag (w=1)
  task wait_flag(input int w);
    for (int k = 0; k < 5000; k++) begin
      @(negedge core_clk_i);
      if ((w == 0) ? (overflow_flag_o === 1'b1)
                   : (channel_event_flag_o[0] === 1'b1))
        return;
    end
    mismatches++;
    test_done();
  endtask

  initial begin
    void'($urandom(32'hd9ae));
    repeat (10) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    chk("overflow_flag", 16'h0000, 16'(overflow_flag_o));
    mod = 16'(8 + $urandom_range(32));
    cv  = 16'(1 + $urandom_range(int'(mod) - 2));
    wr16(MODW, mod);
    tsc_cfg_i = tsc_cfg_t'(6'h08);
    strobe(TSC);
    wait_flag(0);
    chk("counter_at_wrap", 16'h0000, counter_value_o);
    // Write-zero without a prior read must not clear
    strobe(OVF + 1);
    chk("overflow_unarmed", 16'h0001, 16'(overflow_flag_o));
    strobe(OVF);
    strobe(OVF + 1);
    chk("overflow_cleared", 16'h0000, 16'(overflow_flag_o));
    strobe(CNTW);
    chk("counter_cleared", 16'h0000, counter_value_o);
    ch_cfg_i = ch_cfg_t'(4'h5);
    strobe(CHSC);
    wr16(CVW, cv);
    wait_flag(1);
    chk("counter_at_match", cv, counter_value_o);
    chk("compare_toggle", 16'h0001, 16'(channel_out_o[0]));
    strobe(CHF);
    strobe(CHF + 1);
    chk("ch_flag_cleared", 16'h0000, 16'(channel_event_flag_o[0]));
    // Capture mode with no edge: value writes are dropped
    ch_cfg_i = ch_cfg_t'(4'h0);
    strobe(CHSC);
    wr16(CVW, ~cv);
    rd16(CVR, v);
    chk("capture_value", cv, v);
    for (e = 0; e < 4; e++) begin
      ch_cfg_i = ch_cfg_t'({2'b00, 2'(e)});
      strobe(CHSC);
      ch_pin_i[0] = 1'b1;
      repeat (6) @(negedge core_clk_i);
      chk("rise_flag", cap_exp(e, 1), 16'(channel_event_flag_o[0]));
      strobe(CHF);
      strobe(CHF + 1);
      ch_pin_i[0] = 1'b0;
      repeat (6) @(negedge core_clk_i);
      chk("fall_flag", cap_exp(e, 0), 16'(channel_event_flag_o[0]));
      strobe(CHF);
      strobe(CHF + 1);
    end
    // Half a coherent read, then halt: the latch must not leak through
    strobe(CNTR);
    debug_halt_mode_i = 1'b1;
    strobe(CNTW);
    rd16(CNTR, v);
    chk("halted_counter", 16'h0000, v);
    // Halted counter write dropped the latch, so a lone low read is live
    debug_halt_mode_i = 1'b0;
    strobe(CNTR + 1);
    chk("unlatched_low", 16'h0001, 16'(rdata_o));
    // Centre PWM with channel value equal to modulo stays fully on
    ch_cfg_i = ch_cfg_t'(4'hA);
    strobe(CHSC);
    tsc_cfg_i = tsc_cfg_t'(6'h28);
    strobe(TSC);
    wr16(CVW, mod);
    repeat (200) @(negedge core_clk_i);
    for (int k = 0; k < 2 * int'(mod); k++) begin
      @(negedge core_clk_i);
      chk("centre_full_duty", 16'h0001, 16'(channel_out_o[0]));
    end
    test_done();
  end
endmodule // test_timer_pwm_unit

/* File: verilog/pin_sync.sv */
// Three-stage synchroniser with edge pulses for the channel input pins.
// Assumes pins are asynchronous to core_clk_i; an edge counts once the
// second and third stages agree on a new level.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  logic             core_clk_i,
  input  logic             rst_b_i,
  input  logic             clk_en_i,
  input  logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;
  logic [WIDTH-1:0] upd;

  always_comb begin
    upd         = ~(s2_reg ^ s3_reg) & (s3_reg ^ stable_reg);
    stable_next = (stable_reg & ~upd) | (s3_reg & upd);
    rise_o      = upd & s3_reg;
    fall_o      = upd & ~s3_reg;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      stable_reg <= '0;
    end else if (clk_en_i) begin
      s1_reg     <= pin_i;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end

endmodule // pin_sync

/* File: verilog/timer_pwm_pkg.sv */
// Shared constants, modes and carriers of the timer/PWM unit.
// Assumes one bus-side clock domain; all strobes are one-cycle pulses.
package timer_pwm_pkg;

  localparam int NUM_CH   = 2;
  localparam int CH_SEL_W = 1;
  localparam int PRESC_W  = 7;

  localparam logic [15:0]        CNT_ZERO     = 16'h0000;
  localparam logic [15:0]        CNT_ONE      = 16'h0001;
  localparam logic [15:0]        CNT_FREE_TOP = 16'hFFFF;
  localparam logic [PRESC_W-1:0] PRESC_ZERO   = 7'h00;
  localparam logic [PRESC_W-1:0] PRESC_ONE    = 7'h01;
  localparam logic [7:0]         BYTE_ZERO    = 8'h00;
  localparam logic [1:0]         PEND_NONE    = 2'h0;
  localparam int                 PEND_HI      = 1;
  localparam int                 PEND_LO      = 0;

  // Clock source select: zero stops the counter
  localparam logic [1:0] CLK_OFF = 2'h0;

  // Edge/level select encodings
  localparam logic [1:0] ELS_RISE   = 2'h1;
  localparam logic [1:0] ELS_FALL   = 2'h2;
  localparam logic [1:0] ELS_BOTH   = 2'h3;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR  = 2'h2;
  localparam logic [1:0] ELS_SET    = 2'h3;

  typedef enum logic [1:0] {
    MODE_CAPTURE    = 2'b00,
    MODE_COMPARE    = 2'b01,
    MODE_EDGE_PWM   = 2'b10,
    MODE_CENTRE_PWM = 2'b11
  } ch_mode_t;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;

  typedef struct packed {
    logic       center_align_select;
    logic [1:0] clock_source_select;
    logic [2:0] prescale;
  } tsc_cfg_t;

  typedef struct packed {
    logic [1:0] mode_sel;
    logic [1:0] edge_level_select;
  } ch_cfg_t;

  localparam tsc_cfg_t TSC_RST    = tsc_cfg_t'(6'h00);
  localparam ch_cfg_t  CH_CFG_RST = ch_cfg_t'(4'h0);

endpackage

/* File: verilog/timer_pwm_unit.sv */
// Timer/PWM unit: 16-bit counter with prescaler, overflow flag and
// NUM_CH channels (capture, compare, edge and centre PWM).
// Assumes byte-wide register strobes from a CPU on core_clk_i and a
// debug-halt level from the debug logic on the same clock.
`timescale 1ns/100ps
module timer_pwm_unit (
  input  logic                                core_clk_i,
  input  logic                                rst_b_i,
  input  logic                                clk_en_i,
  input  logic                                debug_halt_mode_i,
  input  logic [7:0]                          wdata_i,
  input  logic                                tsc_wr_i,
  input  timer_pwm_pkg::tsc_cfg_t             tsc_cfg_i,
  input  logic                                cnt_wr_i,
  input  logic                                cnt_rd_hi_i,
  input  logic                                cnt_rd_lo_i,
  input  logic                                mod_wr_hi_i,
  input  logic                                mod_wr_lo_i,
  input  logic                                ovf_rd_i,
  input  logic                                ovf_clr_i,
  input  logic [timer_pwm_pkg::CH_SEL_W-1:0]  ch_sel_i,
  input  logic                                chsc_wr_i,
  input  timer_pwm_pkg::ch_cfg_t              ch_cfg_i,
  input  logic                                cv_wr_hi_i,
  input  logic                                cv_wr_lo_i,
  input  logic                                cv_rd_hi_i,
  input  logic                                cv_rd_lo_i,
  input  logic                                ch_flag_rd_i,
  input  logic                                ch_flag_clr_i,
  input  logic [timer_pwm_pkg::NUM_CH-1:0]    ch_pin_i,
  output logic [7:0]                          rdata_o,
  output logic                                overflow_flag_o,
  output logic [timer_pwm_pkg::NUM_CH-1:0]    channel_event_flag_o,
  output logic [timer_pwm_pkg::NUM_CH-1:0]    channel_out_o,
  output logic [15:0]                         counter_value_o
);
  import timer_pwm_pkg::*;

  // Returns {flag, armed}; a new event always wins and disarms the clear
  function automatic logic [1:0] flag_step(input logic flag,
                                           input logic armed,
                                           input logic rd,
                                           input logic clr,
                                           input logic evt);
    logic f;
    logic a;
    f = flag;
    a = armed;
    if (rd && flag) a = 1'b1;
    if (clr && armed) begin
      f = 1'b0;
      a = 1'b0;
    end
    if (evt) begin
      f = 1'b1;
      a = 1'b0;
    end
    return {f, a};
  endfunction

  function automatic ch_mode_t ch_mode(input ch_cfg_t cfg,
                                       input logic center);
    if (center) return MODE_CENTRE_PWM;
    else if (cfg.mode_sel[1]) return MODE_EDGE_PWM;
    else if (cfg.mode_sel[0]) return MODE_COMPARE;
    else return MODE_CAPTURE;
  endfunction

  function automatic logic [PRESC_W-1:0] presc_top(input logic [2:0] ps);
    return (PRESC_ONE << ps) - PRESC_ONE;
  endfunction

  // Timer state
  tsc_cfg_t           tsc_reg,       tsc_next;
  logic [PRESC_W-1:0] presc_reg,     presc_next;
  logic [15:0]        cnt_reg,       cnt_next;
  count_dir_t         dir_reg,       dir_next;
  logic [15:0]        mod_reg,       mod_next;
  logic [15:0]        mod_buf_reg,   mod_buf_next;
  logic [1:0]         mod_pend_reg,  mod_pend_next;
  logic               ovf_reg,       ovf_next;
  logic               ovf_armed_reg, ovf_armed_next;
  logic [7:0]         cnt_latch_reg, cnt_latch_next;
  logic               cnt_lv_reg,    cnt_lv_next;

  logic        clk_on;
  logic        running;
  logic        tick;
  logic        ovf_evt;
  logic [15:0] term;
  logic [7:0]  cnt_rbyte;
  logic [7:0]  cnt_lo;

  // Channel state
  ch_cfg_t     cfg_reg      [NUM_CH];
  ch_cfg_t     cfg_next     [NUM_CH];
  logic [15:0] cv_reg       [NUM_CH];
  logic [15:0] cv_next      [NUM_CH];
  logic [15:0] cv_buf_reg   [NUM_CH];
  logic [15:0] cv_buf_next  [NUM_CH];
  logic [1:0]  cv_pend_reg  [NUM_CH];
  logic [1:0]  cv_pend_next [NUM_CH];
  logic [15:0] duty_reg     [NUM_CH];
  logic [15:0] duty_next    [NUM_CH];
  logic [7:0]  cv_latch_reg [NUM_CH];
  logic [7:0]  cv_latch_next[NUM_CH];
  logic [NUM_CH-1:0] cv_lv_reg,    cv_lv_next;
  logic [NUM_CH-1:0] flag_reg,     flag_next;
  logic [NUM_CH-1:0] armed_reg,    armed_next;
  logic [NUM_CH-1:0] out_reg,      out_next;
  logic [7:0]        rdata_reg,    rdata_next;
  logic [NUM_CH-1:0] pin_rise;
  logic [NUM_CH-1:0] pin_fall;

  pin_sync #(
    .WIDTH (NUM_CH)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .clk_en_i   (clk_en_i),
    .pin_i      (ch_pin_i),
    .rise_o     (pin_rise),
    .fall_o     (pin_fall)
  );

  assign clk_on  = tsc_reg.clock_source_select != CLK_OFF;
  // Debug halt freezes the count so halted reads see a still value
  assign running = clk_on && !debug_halt_mode_i && clk_en_i;
  assign tick    = running && !cnt_wr_i
                   && (presc_reg == presc_top(tsc_reg.prescale));
  assign term    = (mod_reg == CNT_ZERO) ? CNT_FREE_TOP : mod_reg;
  assign cnt_lo  = cnt_reg[7:0];

  always_comb begin
    tsc_next      = tsc_wr_i ? tsc_cfg_i : tsc_reg;
    cnt_next      = cnt_reg;
    dir_next      = dir_reg;
    ovf_evt       = 1'b0;
    presc_next    = presc_reg;
    if (cnt_wr_i) begin
      cnt_next   = CNT_ZERO;
      presc_next = PRESC_ZERO;
      dir_next   = DIR_UP;
    end else if (running) begin
      presc_next = tick ? PRESC_ZERO : presc_reg + PRESC_ONE;
    end
    if (tick) begin
      if (!tsc_reg.center_align_select) begin
        if (cnt_reg == term) begin
          cnt_next = CNT_ZERO;
          ovf_evt  = 1'b1;
        end else begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end else begin
        case (dir_reg)
          DIR_UP: begin
            if (cnt_reg >= term) begin
              dir_next = DIR_DOWN;
              cnt_next = cnt_reg - CNT_ONE;
              ovf_evt  = 1'b1;
            end else begin
              cnt_next = cnt_reg + CNT_ONE;
            end
          end
          DIR_DOWN: begin
            if (cnt_reg == CNT_ZERO) begin
              dir_next = DIR_UP;
              cnt_next = CNT_ONE;
            end else begin
              cnt_next = cnt_reg - CNT_ONE;
            end
          end
          default: dir_next = DIR_UP;
        endcase
      end
    end
    // Modulo takes both bytes as one; a control write drops a half write
    mod_buf_next  = mod_buf_reg;
    mod_pend_next = mod_pend_reg;
    mod_next      = mod_reg;
    if (tsc_wr_i) begin
      mod_pend_next = PEND_NONE;
    end else begin
      if (mod_wr_hi_i) begin
        mod_buf_next[15:8]     = wdata_i;
        mod_pend_next[PEND_HI] = 1'b1;
      end
      if (mod_wr_lo_i) begin
        mod_buf_next[7:0]      = wdata_i;
        mod_pend_next[PEND_LO] = 1'b1;
      end
      if (&mod_pend_next) begin
        mod_next      = mod_buf_next;
        mod_pend_next = PEND_NONE;
      end
    end
    {ovf_next, ovf_armed_next} =
      flag_step(ovf_reg, ovf_armed_reg, ovf_rd_i, ovf_clr_i, ovf_evt);
    // Reading the high byte holds the low byte for a coherent pair
    cnt_latch_next = cnt_latch_reg;
    cnt_lv_next    = cnt_lv_reg;
    if (debug_halt_mode_i) begin
      if (tsc_wr_i || cnt_wr_i) cnt_lv_next = 1'b0;
    end else if (cnt_rd_hi_i) begin
      cnt_latch_next = cnt_reg[7:0];
      cnt_lv_next    = 1'b1;
    end else if (cnt_rd_lo_i) begin
      cnt_lv_next = 1'b0;
    end
    if (cnt_rd_hi_i) cnt_rbyte = cnt_reg[15:8];
    else if (debug_halt_mode_i || !cnt_lv_reg) cnt_rbyte = cnt_reg[7:0];
    else cnt_rbyte = cnt_latch_reg;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tsc_reg       <= TSC_RST;
      presc_reg     <= PRESC_ZERO;
      cnt_reg       <= CNT_ZERO;
      dir_reg       <= DIR_UP;
      mod_reg       <= CNT_ZERO;
      mod_buf_reg   <= CNT_ZERO;
      mod_pend_reg  <= PEND_NONE;
      ovf_reg       <= 1'b0;
      ovf_armed_reg <= 1'b0;
      cnt_latch_reg <= BYTE_ZERO;
      cnt_lv_reg    <= 1'b0;
    end else if (clk_en_i) begin
      tsc_reg       <= tsc_next;
      presc_reg     <= presc_next;
      cnt_reg       <= cnt_next;
      dir_reg       <= dir_next;
      mod_reg       <= mod_next;
      mod_buf_reg   <= mod_buf_next;
      mod_pend_reg  <= mod_pend_next;
      ovf_reg       <= ovf_next;
      ovf_armed_reg <= ovf_armed_next;
      cnt_latch_reg <= cnt_latch_next;
      cnt_lv_reg    <= cnt_lv_next;
    end
  end

  always_comb begin
    ch_mode_t md;
    logic     sel;
    logic     match;
    logic     evt;
    logic     ld;
    logic     act;
    logic     pwm_on;
    logic [1:0] els;
    md     = MODE_CAPTURE;
    sel    = 1'b0;
    match  = 1'b0;
    evt    = 1'b0;
    ld     = 1'b0;
    act    = 1'b0;
    pwm_on = 1'b0;
    els    = 2'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      sel   = (ch_sel_i == CH_SEL_W'(i));
      md    = ch_mode(cfg_reg[i], tsc_reg.center_align_select);
      els   = cfg_reg[i].edge_level_select;
      match = tick && (cnt_next == cv_reg[i]);
      cfg_next[i]     = (sel && chsc_wr_i) ? ch_cfg_i : cfg_reg[i];
      cv_buf_next[i]  = cv_buf_reg[i];
      cv_pend_next[i] = cv_pend_reg[i];
      cv_next[i]      = cv_reg[i];
      if (sel && chsc_wr_i) begin
        cv_pend_next[i] = PEND_NONE;
      end else if (sel && md != MODE_CAPTURE) begin
        if (cv_wr_hi_i) begin
          cv_buf_next[i][15:8]     = wdata_i;
          cv_pend_next[i][PEND_HI] = 1'b1;
        end
        if (cv_wr_lo_i) begin
          cv_buf_next[i][7:0]      = wdata_i;
          cv_pend_next[i][PEND_LO] = 1'b1;
        end
      end
      // Buffered value moves over at a safe point of the count, or at once with the clock source off
      ld = 1'b0;
      if (&cv_pend_reg[i] && md != MODE_CAPTURE) begin
        if (!clk_on) ld = 1'b1;
        else if (md == MODE_COMPARE) ld = tick;
        else ld = tick && dir_reg == DIR_UP
                  && cnt_reg == term - CNT_ONE;
      end
      if (ld) begin
        cv_next[i]      = cv_buf_reg[i];
        cv_pend_next[i] = PEND_NONE;
      end
      evt = 1'b0;
      if (md == MODE_CAPTURE) begin
        case (els)
          ELS_RISE: evt = pin_rise[i];
          ELS_FALL: evt = pin_fall[i];
          ELS_BOTH: evt = pin_rise[i] | pin_fall[i];
          default:  evt = 1'b0;
        endcase
        if (evt) cv_next[i] = cnt_reg;
      end else begin
        evt = match;
      end
      // Centre duty is sampled at the period boundary only
      duty_next[i] = ovf_evt ? cv_next[i] : duty_reg[i];
      out_next[i]  = out_reg[i];
      act          = ~els[0];
      pwm_on = (duty_reg[i] != CNT_ZERO) && !duty_reg[i][15]
               && ((duty_reg[i] >= term) || (cnt_next < duty_reg[i]));
      case (md)
        MODE_COMPARE: begin
          if (match) begin
            case (els)
              ELS_TOGGLE: out_next[i] = ~out_reg[i];
              ELS_CLEAR:  out_next[i] = 1'b0;
              ELS_SET:    out_next[i] = 1'b1;
              default:    out_next[i] = out_reg[i];
            endcase
          end
        end
        MODE_EDGE_PWM: begin
          // Only a counter step moves the output, so clock off holds it
          if (tick) begin
            if (match) out_next[i] = ~act;
            else if (cnt_next == CNT_ZERO) out_next[i] = act;
          end
        end
        MODE_CENTRE_PWM: begin
          if (tick) out_next[i] = pwm_on ^ els[0];
        end
        default: out_next[i] = out_reg[i];
      endcase
      {flag_next[i], armed_next[i]} = flag_step(flag_reg[i], armed_reg[i],
        sel && ch_flag_rd_i, sel && ch_flag_clr_i, evt);
      cv_latch_next[i] = cv_latch_reg[i];
      cv_lv_next[i]    = cv_lv_reg[i];
      if (debug_halt_mode_i) begin
        if (sel && chsc_wr_i) cv_lv_next[i] = 1'b0;
      end else if (sel && cv_rd_hi_i) begin
        cv_latch_next[i] = cv_reg[i][7:0];
        cv_lv_next[i]    = 1'b1;
      end else if (sel && cv_rd_lo_i) begin
        cv_lv_next[i] = 1'b0;
      end
    end
    rdata_next = rdata_reg;
    if (cnt_rd_hi_i || cnt_rd_lo_i) rdata_next = cnt_rbyte;
    else if (cv_rd_hi_i) rdata_next = cv_reg[ch_sel_i][15:8];
    else if (cv_rd_lo_i) begin
      if (debug_halt_mode_i || !cv_lv_reg[ch_sel_i])
        rdata_next = cv_reg[ch_sel_i][7:0];
      else
        rdata_next = cv_latch_reg[ch_sel_i];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_reg[i]      <= CH_CFG_RST;
        cv_reg[i]       <= CNT_ZERO;
        cv_buf_reg[i]   <= CNT_ZERO;
        cv_pend_reg[i]  <= PEND_NONE;
        duty_reg[i]     <= CNT_ZERO;
        cv_latch_reg[i] <= BYTE_ZERO;
      end
      cv_lv_reg <= '0;
      flag_reg  <= '0;
      armed_reg <= '0;
      out_reg   <= '0;
      rdata_reg <= BYTE_ZERO;
    end else if (clk_en_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_reg[i]      <= cfg_next[i];
        cv_reg[i]       <= cv_next[i];
        cv_buf_reg[i]   <= cv_buf_next[i];
        cv_pend_reg[i]  <= cv_pend_next[i];
        duty_reg[i]     <= duty_next[i];
        cv_latch_reg[i] <= cv_latch_next[i];
      end
      cv_lv_reg <= cv_lv_next;
      flag_reg  <= flag_next;
      armed_reg <= armed_next;
      out_reg   <= out_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o              = rdata_reg;
  assign overflow_flag_o      = ovf_reg;
  assign channel_event_flag_o = flag_reg;
  assign channel_out_o        = out_reg;
  assign counter_value_o      = cnt_reg;

  property p_wrap_ovf;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    tick && !tsc_reg.center_align_select && cnt_reg == term
    |=> ovf_reg && cnt_reg == CNT_ZERO;
  endproperty
  a_wrap_ovf: assert property (p_wrap_ovf)
    else $error("overflow flag missing at counter wrap");

  property p_top_ovf;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    tick && tsc_reg.center_align_select && dir_reg == DIR_UP
    && cnt_reg >= term |=> ovf_reg && dir_reg == DIR_DOWN;
  endproperty
  a_top_ovf: assert property (p_top_ovf)
    else $error("centre overflow flag missing at reversal");

  property p_event_wins;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    clk_en_i && ovf_evt |=> ovf_reg && !ovf_armed_reg;
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("overflow event lost or clear left armed");

  property p_cnt_clear;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    clk_en_i && cnt_wr_i |=> cnt_reg == CNT_ZERO && presc_reg == PRESC_ZERO;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("counter write did not clear counter and prescaler");

  property p_halt_read;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    clk_en_i && debug_halt_mode_i && cnt_rd_lo_i && !cnt_rd_hi_i
    |=> rdata_reg == $past(cnt_lo);
  endproperty
  a_halt_read: assert property (p_halt_read)
    else $error("halted counter read returned stale byte");

  property p_halt_unlatch;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    clk_en_i && debug_halt_mode_i && (tsc_wr_i || cnt_wr_i)
    |=> !cnt_lv_reg;
  endproperty
  a_halt_unlatch: assert property (p_halt_unlatch)
    else $error("halted write left counter read latch set");

  property p_cmp_flag;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    ch_mode(cfg_reg[0], tsc_reg.center_align_select) == MODE_COMPARE
    && tick && cnt_next == cv_reg[0] |=> flag_reg[0];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("compare match did not set channel flag");

  property p_cap_nowrite;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    clk_en_i && ch_sel_i == CH_SEL_W'(0) && !chsc_wr_i
    && ch_mode(cfg_reg[0], tsc_reg.center_align_select) == MODE_CAPTURE
    && (cv_wr_hi_i || cv_wr_lo_i) |=> $stable(cv_buf_reg[0]);
  endproperty
  a_cap_nowrite: assert property (p_cap_nowrite)
    else $error("capture channel accepted a value write");

  property p_clk_off_freeze;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !clk_on ##1 !clk_on |-> $stable(out_reg);
  endproperty
  a_clk_off_freeze: assert property (p_clk_off_freeze)
    else $error("channel output moved with clock source off");

endmodule // timer_pwm_unit
